//--- pkg/pfs_pkg.sv
// pfs_pkg: register map, field codes and routing types for the pin function select block
package pfs_pkg;

    localparam int REG_COUNT = 11;
    localparam int DATA_W = 32;
    localparam int FIELD_W = 2;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_PORT_A_HIGH_FUNCTION_SELECT = 4'h0;
    localparam logic [3:0] IDX_PORT_B_LOW_FUNCTION_SELECT = 4'h1;
    localparam logic [3:0] IDX_PORT_B_HIGH_FUNCTION_SELECT = 4'h2;
    localparam logic [3:0] IDX_PORT_C_LOW_FUNCTION_SELECT = 4'h3;
    localparam logic [3:0] IDX_PORT_C_HIGH_FUNCTION_SELECT = 4'h4;
    localparam logic [3:0] IDX_PORT_D_LOW_FUNCTION_SELECT = 4'h5;
    localparam logic [3:0] IDX_PORT_D_HIGH_FUNCTION_SELECT = 4'h6;
    localparam logic [3:0] IDX_PORT_E_LOW_FUNCTION_SELECT = 4'h7;
    localparam logic [3:0] IDX_PORT_E_HIGH_FUNCTION_SELECT = 4'h8;
    localparam logic [3:0] IDX_PORT_F_LOW_FUNCTION_SELECT = 4'h9;
    localparam logic [3:0] IDX_PORT_F_HIGH_FUNCTION_SELECT = 4'hA;

    typedef logic [REG_COUNT-1:0][7:0] pfs_regs_t;

    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_PORT_B_HIGH = 8'hFC;
    localparam logic [7:0] MASK_LOW_NIBBLE = 8'h0F;

    // writable bits per register, highest index first
    localparam pfs_regs_t WRITE_MASK = {
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_LOW_NIBBLE, MASK_FULL,
        MASK_LOW_NIBBLE, MASK_FULL, MASK_PORT_B_HIGH, MASK_FULL, MASK_FULL};

    // field lsb positions inside a register
    localparam int FLD_BIT0 = 0;
    localparam int FLD_BIT1 = 2;
    localparam int FLD_BIT2 = 4;
    localparam int FLD_BIT3 = 6;

    // field codes
    localparam logic [1:0] SEL_CODE_00 = 2'h0;
    localparam logic [1:0] SEL_CODE_01 = 2'h1;
    localparam logic [1:0] SEL_CODE_10 = 2'h2;
    localparam logic [1:0] SEL_CODE_11 = 2'h3;

    // segment numbering bases
    localparam int SEG_BASE_E = 28;
    localparam int SEG_BASE_F = 20;

    typedef struct packed {
        logic [44:0] lcd_seg_en;
        logic [3:0] lcd_com_en;
        logic [5:0] analog_en;
        logic vref_en;
        logic lcd_bias_node;
        logic opamp2_output;
        logic opamp2_inverting_in;
        logic serial_data_in_shared;
        logic serial_a_data_in_pa6;
        logic serial_a_data_in_pb3;
        logic serial_a_clock_pa5;
        logic serial_a_clock_pb2;
        logic serial_a_chip_select_pa4;
        logic serial_a_chip_select_pc4;
        logic serial_a_data_out;
        logic serial_chip_select;
        logic serial_data_out;
        logic uart_first_receive;
        logic uart_first_transmit;
        logic uart_second_receive;
        logic uart_second_transmit;
        logic oscillator_pin_one;
        logic periodic_timer2_out_pa4;
        logic periodic_timer2_out_pc2;
        logic periodic_timer1_out;
        logic standard_timer_out;
        logic standard_timer_inverted_out;
        logic overvoltage_protect_in_pb1;
        logic overvoltage_protect_in_pd5;
        logic [7:4] gpio_a;
        logic [7:0] gpio_b;
        logic [5:0] gpio_c;
        logic [5:0] gpio_d;
        logic [7:0] gpio_e;
        logic [7:0] gpio_f;
    } pfs_route_t;

endpackage

//--- hw/pfs_mux.sv
// pfs_mux: APB register file and pad function routing decode
`timescale 1ns/100ps

// Overview of operation
// - PA7 field: 00 and 10 GPIO, 01 segment 42, 11 shared serial input.
// - PA6 field: 00 GPIO, 01 segment 43, 10 serial A input, 11 UART0 receive.
// - PA5 field: 00 GPIO, 01 serial A clock, 10 segment 44, 11 UART0 transmit.
// - PA4 field: 00 GPIO, 01 timer2 output, 10 serial A select, 11 oscillator.
// - PB3 field: 00 GPIO, 01 segment 38, 10 serial A input, 11 serial output.
// - PB2 field: 00 GPIO, 01 segment 39, 10 serial select, 11 serial A clock.
// - PB1 field: 00 GPIO, 01 segment 40, 10 inverted timer out, 11 overvoltage.
// - PB7..PB5 give GPIO except 11: bias node, opamp output, opamp inverting input.
// - two lowest bits of port B high register unimplemented, read zero.
// - PC3 gives GPIO except code 11 selecting analog channel 1.
// - PC2 field: 00 GPIO, 01 timer2 output, 10 reference, 11 analog 0.
// - PC0: 00/01 GPIO, 10 timer1 output, 11 analog channel 2.
// - PC5 field: 00 GPIO, 01 serial A output, 10 UART1 transmit, 11 analog 5.
// - PC4 field: 00 GPIO, 01 serial A select, 10 UART1 receive, 11 analog 4.
// - PD0..PD3: 00/01 GPIO, 10 segment n, 11 common n plus 4.
// - PD5: 00/01 GPIO, 10 overvoltage input, 11 segment 37.
// - PD4: 00/01 GPIO, 10 standard timer output, 11 segment 36.
// - port E bit k: 11 selects segment 28 plus k, else GPIO.
// - port F bit k: 11 selects segment 20 plus k, else GPIO.
// - upper nibbles of port C and D high registers read zero.
module pfs_mux #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [pfs_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pfs_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output pfs_pkg::pfs_route_t route
);

    pfs_pkg::pfs_regs_t sel_r;
    pfs_pkg::pfs_regs_t sel_nxt;
    pfs_pkg::pfs_route_t route_r;
    logic [pfs_pkg::DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [3:0] idx;
    logic hit;
    logic setup;
    logic access_done;
    logic wr_en;

    // field-to-route decode, shared by every register
    function automatic pfs_pkg::pfs_route_t pfs_decode(input pfs_pkg::pfs_regs_t r);
        pfs_pkg::pfs_route_t o;
        logic [1:0] porta_bit7_func_field;
        logic [1:0] porta_bit6_func_field;
        logic [1:0] porta_bit5_func_field;
        logic [1:0] porta_bit4_func_field;
        logic [1:0] portb_bit3_func_field;
        logic [1:0] portb_bit2_func_field;
        logic [1:0] portb_bit1_func_field;
        logic [1:0] portc_bit3_func_field;
        logic [1:0] portc_bit2_func_field;
        logic [1:0] portc_bit1_func_field;
        logic [1:0] portc_bit0_func_field;
        logic [1:0] portc_bit5_func_field;
        logic [1:0] portc_bit4_func_field;
        logic [1:0] portd_bit5_func_field;
        logic [1:0] portd_bit4_func_field;
        logic [1:0] f;
        o = '0;
        o.gpio_a = '1;
        o.gpio_b = '1;
        o.gpio_c = '1;
        o.gpio_d = '1;
        o.gpio_e = '1;
        o.gpio_f = '1;
        porta_bit7_func_field = r[pfs_pkg::IDX_PORT_A_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT3 +: 2];
        porta_bit6_func_field = r[pfs_pkg::IDX_PORT_A_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT2 +: 2];
        porta_bit5_func_field = r[pfs_pkg::IDX_PORT_A_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT1 +: 2];
        porta_bit4_func_field = r[pfs_pkg::IDX_PORT_A_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT0 +: 2];
        portb_bit3_func_field = r[pfs_pkg::IDX_PORT_B_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT3 +: 2];
        portb_bit2_func_field = r[pfs_pkg::IDX_PORT_B_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT2 +: 2];
        portb_bit1_func_field = r[pfs_pkg::IDX_PORT_B_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT1 +: 2];
        portc_bit3_func_field = r[pfs_pkg::IDX_PORT_C_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT3 +: 2];
        portc_bit2_func_field = r[pfs_pkg::IDX_PORT_C_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT2 +: 2];
        portc_bit1_func_field = r[pfs_pkg::IDX_PORT_C_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT1 +: 2];
        portc_bit0_func_field = r[pfs_pkg::IDX_PORT_C_LOW_FUNCTION_SELECT][pfs_pkg::FLD_BIT0 +: 2];
        portc_bit5_func_field = r[pfs_pkg::IDX_PORT_C_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT1 +: 2];
        portc_bit4_func_field = r[pfs_pkg::IDX_PORT_C_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT0 +: 2];
        portd_bit5_func_field = r[pfs_pkg::IDX_PORT_D_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT1 +: 2];
        portd_bit4_func_field = r[pfs_pkg::IDX_PORT_D_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT0 +: 2];

        // port A high half; code 10 on PA7 stays general I/O
        o.lcd_seg_en[42] = porta_bit7_func_field == pfs_pkg::SEL_CODE_01;
        o.serial_data_in_shared = porta_bit7_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_a[7] = !(o.lcd_seg_en[42] || o.serial_data_in_shared);
        o.lcd_seg_en[43] = porta_bit6_func_field == pfs_pkg::SEL_CODE_01;
        o.serial_a_data_in_pa6 = porta_bit6_func_field == pfs_pkg::SEL_CODE_10;
        o.uart_first_receive = porta_bit6_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_a[6] = porta_bit6_func_field == pfs_pkg::SEL_CODE_00;
        o.serial_a_clock_pa5 = porta_bit5_func_field == pfs_pkg::SEL_CODE_01;
        o.lcd_seg_en[44] = porta_bit5_func_field == pfs_pkg::SEL_CODE_10;
        o.uart_first_transmit = porta_bit5_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_a[5] = porta_bit5_func_field == pfs_pkg::SEL_CODE_00;
        o.periodic_timer2_out_pa4 = porta_bit4_func_field == pfs_pkg::SEL_CODE_01;
        o.serial_a_chip_select_pa4 = porta_bit4_func_field == pfs_pkg::SEL_CODE_10;
        o.oscillator_pin_one = porta_bit4_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_a[4] = porta_bit4_func_field == pfs_pkg::SEL_CODE_00;

        // port B; PB0 and PB4 have no alternate function and stay I/O
        o.lcd_seg_en[38] = portb_bit3_func_field == pfs_pkg::SEL_CODE_01;
        o.serial_a_data_in_pb3 = portb_bit3_func_field == pfs_pkg::SEL_CODE_10;
        o.serial_data_out = portb_bit3_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_b[3] = portb_bit3_func_field == pfs_pkg::SEL_CODE_00;
        o.lcd_seg_en[39] = portb_bit2_func_field == pfs_pkg::SEL_CODE_01;
        o.serial_chip_select = portb_bit2_func_field == pfs_pkg::SEL_CODE_10;
        o.serial_a_clock_pb2 = portb_bit2_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_b[2] = portb_bit2_func_field == pfs_pkg::SEL_CODE_00;
        o.lcd_seg_en[40] = portb_bit1_func_field == pfs_pkg::SEL_CODE_01;
        o.standard_timer_inverted_out = portb_bit1_func_field == pfs_pkg::SEL_CODE_10;
        o.overvoltage_protect_in_pb1 = portb_bit1_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_b[1] = portb_bit1_func_field == pfs_pkg::SEL_CODE_00;
        f = r[pfs_pkg::IDX_PORT_B_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT3 +: 2];
        o.lcd_bias_node = f == pfs_pkg::SEL_CODE_11;
        o.gpio_b[7] = !o.lcd_bias_node;
        f = r[pfs_pkg::IDX_PORT_B_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT2 +: 2];
        o.opamp2_output = f == pfs_pkg::SEL_CODE_11;
        o.gpio_b[6] = !o.opamp2_output;
        f = r[pfs_pkg::IDX_PORT_B_HIGH_FUNCTION_SELECT][pfs_pkg::FLD_BIT1 +: 2];
        o.opamp2_inverting_in = f == pfs_pkg::SEL_CODE_11;
        o.gpio_b[5] = !o.opamp2_inverting_in;

        // port C
        o.analog_en[1] = portc_bit3_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_c[3] = !o.analog_en[1];
        o.periodic_timer2_out_pc2 = portc_bit2_func_field == pfs_pkg::SEL_CODE_01;
        o.vref_en = portc_bit2_func_field == pfs_pkg::SEL_CODE_10;
        o.analog_en[0] = portc_bit2_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_c[2] = portc_bit2_func_field == pfs_pkg::SEL_CODE_00;
        o.analog_en[3] = portc_bit1_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_c[1] = !o.analog_en[3];
        o.periodic_timer1_out = portc_bit0_func_field == pfs_pkg::SEL_CODE_10;
        o.analog_en[2] = portc_bit0_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_c[0] = !portc_bit0_func_field[1];
        o.serial_a_data_out = portc_bit5_func_field == pfs_pkg::SEL_CODE_01;
        o.uart_second_transmit = portc_bit5_func_field == pfs_pkg::SEL_CODE_10;
        o.analog_en[5] = portc_bit5_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_c[5] = portc_bit5_func_field == pfs_pkg::SEL_CODE_00;
        o.serial_a_chip_select_pc4 = portc_bit4_func_field == pfs_pkg::SEL_CODE_01;
        o.uart_second_receive = portc_bit4_func_field == pfs_pkg::SEL_CODE_10;
        o.analog_en[4] = portc_bit4_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_c[4] = portc_bit4_func_field == pfs_pkg::SEL_CODE_00;

        // port D low: segment n or common n+4
        for (int k = 0; k < 4; k++) begin
            f = r[pfs_pkg::IDX_PORT_D_LOW_FUNCTION_SELECT][2*k +: 2];
            o.lcd_seg_en[k] = f == pfs_pkg::SEL_CODE_10;
            o.lcd_com_en[k] = f == pfs_pkg::SEL_CODE_11;
            o.gpio_d[k] = !f[1];
        end
        o.overvoltage_protect_in_pd5 = portd_bit5_func_field == pfs_pkg::SEL_CODE_10;
        o.lcd_seg_en[37] = portd_bit5_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_d[5] = !portd_bit5_func_field[1];
        o.standard_timer_out = portd_bit4_func_field == pfs_pkg::SEL_CODE_10;
        o.lcd_seg_en[36] = portd_bit4_func_field == pfs_pkg::SEL_CODE_11;
        o.gpio_d[4] = !portd_bit4_func_field[1];

        // ports E and F: each low/high register pair covers bits 0..7
        for (int k = 0; k < 8; k++) begin
            f = r[pfs_pkg::IDX_PORT_E_LOW_FUNCTION_SELECT + k/4][2*(k%4) +: 2];
            o.lcd_seg_en[pfs_pkg::SEG_BASE_E + k] = f == pfs_pkg::SEL_CODE_11;
            o.gpio_e[k] = f != pfs_pkg::SEL_CODE_11;
            f = r[pfs_pkg::IDX_PORT_F_LOW_FUNCTION_SELECT + k/4][2*(k%4) +: 2];
            o.lcd_seg_en[pfs_pkg::SEG_BASE_F + k] = f == pfs_pkg::SEL_CODE_11;
            o.gpio_f[k] = f != pfs_pkg::SEL_CODE_11;
        end
        return o;
    endfunction

    // apb decode
    assign idx = paddr[5:2];
    assign hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:6] == '0)
        && (idx < 4'(pfs_pkg::REG_COUNT));
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready_r;
    assign wr_en = access_done && pwrite && hit && pstrb[0];

    always_comb begin
        sel_nxt = sel_r;
        if (wr_en) begin
            // unimplemented bits never store
            sel_nxt[idx] = pwdata[7:0] & pfs_pkg::WRITE_MASK[idx];
        end
    end

    // one wait-free access phase: ready follows setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup && !pwrite && hit) begin
            prdata_r <= {24'h000000, sel_r[idx]};
        end else if (setup) begin
            prdata_r <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= {pfs_pkg::REG_COUNT{pfs_pkg::SEL_RESET}};
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // routing built from next value, so it moves with the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // every alternate off, every pad general I/O
            route_r <= pfs_pkg::pfs_route_t'{gpio_a: '1, gpio_b: '1, gpio_c: '1, gpio_d: '1,
                gpio_e: '1, gpio_f: '1, default: '0};
        end else begin
            route_r <= pfs_decode(sel_nxt);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign route = route_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pa7_route;
        (route_r.lcd_seg_en[42] == (sel_r[0][7:6] == 2'h1))
            && (route_r.serial_data_in_shared == (sel_r[0][7:6] == 2'h3));
    endproperty
    a_pa7_route: assert property (p_pa7_route) else $error("pa7 routing mismatch");

    property p_pa6_uart;
        route_r.uart_first_receive == (sel_r[0][5:4] == 2'h3);
    endproperty
    a_pa6_uart: assert property (p_pa6_uart) else $error("pa6 uart routing wrong");

    property p_pa4_osc;
        route_r.oscillator_pin_one |-> (sel_r[0][1:0] == 2'h3) && !route_r.gpio_a[4];
    endproperty
    a_pa4_osc: assert property (p_pa4_osc) else $error("pa4 oscillator routing wrong");

    property p_pb3_sdo;
        route_r.serial_data_out == (sel_r[1][7:6] == 2'h3);
    endproperty
    a_pb3_sdo: assert property (p_pb3_sdo) else $error("pb3 serial output wrong");

    property p_pb6_opamp;
        (route_r.opamp2_output == (sel_r[2][5:4] == 2'h3))
            && (route_r.opamp2_output != route_r.gpio_b[6]);
    endproperty
    a_pb6_opamp: assert property (p_pb6_opamp) else $error("pb6 opamp and io both set");

    property p_pb_high_low_zero;
        sel_r[2][1:0] == 2'h0;
    endproperty
    a_pb_high_low_zero: assert property (p_pb_high_low_zero) else $error("pb high bits 1:0 set");

    property p_upper_nibble_read;
        setup && !pwrite && hit && (idx == 4'h4 || idx == 4'h6) |=> prdata[7:4] == 4'h0;
    endproperty
    a_upper_nibble_read: assert property (p_upper_nibble_read) else $error("upper nibble reads set");

    property p_pc2_vref;
        route_r.vref_en == (sel_r[3][5:4] == 2'h2);
    endproperty
    a_pc2_vref: assert property (p_pc2_vref) else $error("pc2 reference routing wrong");

    property p_pd_com;
        route_r.lcd_com_en[3] == (sel_r[5][7:6] == 2'h3);
    endproperty
    a_pd_com: assert property (p_pd_com) else $error("pd3 common routing wrong");

    property p_pe_seg;
        route_r.lcd_seg_en[35] == (sel_r[8][7:6] == 2'h3);
    endproperty
    a_pe_seg: assert property (p_pe_seg) else $error("pe7 segment routing wrong");

    property p_pf_seg;
        (route_r.lcd_seg_en[20] == (sel_r[9][1:0] == 2'h3))
            && (route_r.lcd_seg_en[20] != route_r.gpio_f[0]);
    endproperty
    a_pf_seg: assert property (p_pf_seg) else $error("pf0 segment routing wrong");

    property p_write_to_route;
        access_done && pwrite && hit && pstrb[0] && idx == 4'h0
            |=> route_r.lcd_seg_en[42] == ($past(pwdata[7:6]) == 2'h1);
    endproperty
    a_write_to_route: assert property (p_write_to_route) else $error("route lags the write");

    property p_pa7_code10;
        sel_r[0][7:6] == 2'h2 |-> route_r.gpio_a[7];
    endproperty
    a_pa7_code10: assert property (p_pa7_code10) else $error("pa7 code 10 not io");

    property p_pa5_route;
        (route_r.serial_a_clock_pa5 == (sel_r[0][3:2] == 2'h1))
            && (route_r.lcd_seg_en[44] == (sel_r[0][3:2] == 2'h2));
    endproperty
    a_pa5_route: assert property (p_pa5_route) else $error("pa5 routing mismatch");

    property p_pb2_route;
        (route_r.serial_chip_select == (sel_r[1][5:4] == 2'h2))
            && (route_r.serial_a_clock_pb2 == (sel_r[1][5:4] == 2'h3));
    endproperty
    a_pb2_route: assert property (p_pb2_route) else $error("pb2 routing mismatch");

    property p_pb1_route;
        (route_r.standard_timer_inverted_out == (sel_r[1][3:2] == 2'h2))
            && (route_r.overvoltage_protect_in_pb1 == (sel_r[1][3:2] == 2'h3));
    endproperty
    a_pb1_route: assert property (p_pb1_route) else $error("pb1 routing mismatch");

    property p_pc3_analog;
        (route_r.analog_en[1] == (sel_r[3][7:6] == 2'h3))
            && (route_r.gpio_c[3] != route_r.analog_en[1]);
    endproperty
    a_pc3_analog: assert property (p_pc3_analog) else $error("pc3 analog routing wrong");

    property p_pc0_route;
        (route_r.periodic_timer1_out == (sel_r[3][1:0] == 2'h2))
            && (route_r.gpio_c[0] == !sel_r[3][1]);
    endproperty
    a_pc0_route: assert property (p_pc0_route) else $error("pc0 routing mismatch");

    property p_pc5_route;
        (route_r.uart_second_transmit == (sel_r[4][3:2] == 2'h2))
            && (route_r.analog_en[5] == (sel_r[4][3:2] == 2'h3));
    endproperty
    a_pc5_route: assert property (p_pc5_route) else $error("pc5 routing mismatch");

    property p_pc4_route;
        (route_r.uart_second_receive == (sel_r[4][1:0] == 2'h2))
            && (route_r.serial_a_chip_select_pc4 == (sel_r[4][1:0] == 2'h1));
    endproperty
    a_pc4_route: assert property (p_pc4_route) else $error("pc4 routing mismatch");

    property p_pd5_route;
        (route_r.overvoltage_protect_in_pd5 == (sel_r[6][3:2] == 2'h2))
            && (route_r.lcd_seg_en[37] == (sel_r[6][3:2] == 2'h3));
    endproperty
    a_pd5_route: assert property (p_pd5_route) else $error("pd5 routing mismatch");

    property p_pd4_route;
        (route_r.standard_timer_out == (sel_r[6][1:0] == 2'h2))
            && (route_r.lcd_seg_en[36] == (sel_r[6][1:0] == 2'h3));
    endproperty
    a_pd4_route: assert property (p_pd4_route) else $error("pd4 routing mismatch");

    c_write: cover property (access_done && pwrite && hit);
    c_read: cover property (access_done && !pwrite && hit);
    c_error: cover property (access_done && pslverr_r);
    c_lcd_segment_42: cover property (route_r.lcd_seg_en[42]);
    c_shared_in: cover property (route_r.serial_data_in_shared);

endmodule

//--- sim/pfs_mux_tb.sv
// pfs_mux_tb: self-checking testbench for the pin function select block
`timescale 1ns/100ps
module pfs_mux_tb;
    typedef struct {bit we; bit err; bit upd; int idx; logic [7:0] d;} pfs_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    pfs_pkg::pfs_route_t route, x;
    logic [7:0] sh [11];
    pfs_note_t q[$];
    pfs_note_t n;
    int fails = 0, tests_run = 0, cyc = 0;
    pfs_mux u_pfs_mux (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .route(route));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic bit k(int i, int f, int v);
        return sh[i][2*f+:2] == 2'(v);
    endfunction
    // one-hot of a field code, bit c set for code c
    function automatic logic [3:0] d(int i, int f);
        return 4'h1 << sh[i][2*f+:2];
    endfunction
    function automatic pfs_pkg::pfs_route_t er();
        pfs_pkg::pfs_route_t e;
        e = '0;
        e.gpio_a[7] = !sh[0][6];
        e.lcd_seg_en[42] = k(0,3,1);
        e.serial_data_in_shared = k(0,3,3);
        {e.uart_first_receive, e.serial_a_data_in_pa6, e.lcd_seg_en[43], e.gpio_a[6]} = d(0,2);
        {e.uart_first_transmit, e.lcd_seg_en[44], e.serial_a_clock_pa5, e.gpio_a[5]} = d(0,1);
        {e.oscillator_pin_one, e.serial_a_chip_select_pa4, e.periodic_timer2_out_pa4,
            e.gpio_a[4]} = d(0,0);
        {e.serial_data_out, e.serial_a_data_in_pb3, e.lcd_seg_en[38], e.gpio_b[3]} = d(1,3);
        {e.serial_a_clock_pb2, e.serial_chip_select, e.lcd_seg_en[39], e.gpio_b[2]} = d(1,2);
        {e.overvoltage_protect_in_pb1, e.standard_timer_inverted_out, e.lcd_seg_en[40],
            e.gpio_b[1]} = d(1,1);
        e.gpio_b[4] = 1'b1;
        e.gpio_b[0] = 1'b1;
        {e.lcd_bias_node, e.gpio_b[7]} = {k(2,3,3), !k(2,3,3)};
        {e.opamp2_output, e.gpio_b[6]} = {k(2,2,3), !k(2,2,3)};
        {e.opamp2_inverting_in, e.gpio_b[5]} = {k(2,1,3), !k(2,1,3)};
        {e.analog_en[1], e.gpio_c[3]} = {k(3,3,3), !k(3,3,3)};
        {e.analog_en[0], e.vref_en, e.periodic_timer2_out_pc2, e.gpio_c[2]} = d(3,2);
        {e.analog_en[3], e.gpio_c[1]} = {k(3,1,3), !k(3,1,3)};
        {e.analog_en[2], e.periodic_timer1_out} = 2'(d(3,0) >> 2);
        e.gpio_c[0] = !sh[3][1];
        {e.analog_en[5], e.uart_second_transmit, e.serial_a_data_out, e.gpio_c[5]} = d(4,1);
        {e.analog_en[4], e.uart_second_receive, e.serial_a_chip_select_pc4,
            e.gpio_c[4]} = d(4,0);
        for (int b = 0; b < 4; b++) begin
            {e.lcd_com_en[b], e.lcd_seg_en[b]} = 2'(d(5,b) >> 2);
            e.gpio_d[b] = !sh[5][2*b+1];
        end
        {e.lcd_seg_en[36], e.standard_timer_out} = 2'(d(6,0) >> 2);
        {e.lcd_seg_en[37], e.overvoltage_protect_in_pd5} = 2'(d(6,1) >> 2);
        e.gpio_d[4] = !sh[6][1];
        e.gpio_d[5] = !sh[6][3];
        for (int b = 0; b < 8; b++) begin
            {e.lcd_seg_en[28+b], e.gpio_e[b]} = {k(7+b/4,b%4,3), !k(7+b/4,b%4,3)};
            {e.lcd_seg_en[20+b], e.gpio_f[b]} = {k(9+b/4,b%4,3), !k(9+b/4,b%4,3)};
        end
        return e;
    endfunction
    task automatic xfer(bit w, logic [11:0] a, logic [7:0] v, logic [3:0] s);
        pfs_note_t m;
        int t;
        m.we = w;
        m.err = a[1:0] != 2'h0 || a >= 12'h02C;
        m.idx = int'(a[5:2]);
        m.d = v & (m.idx == 2 ? 8'hFC : (m.idx == 4 || m.idx == 6) ? 8'h0F : 8'hFF);
        m.upd = w && !m.err && s[0];
        q.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), v};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        chk("pready wait", t < 16, 1'b1);
        penable <= 1'b0;
    endtask
    task automatic rd_all();
        for (int i = 0; i < 11; i++)
            xfer(1'b0, 12'(4 * i), 8'h00, 4'hF);
        psel <= 1'b0;
        @(posedge pclk);
    endtask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 11; i++)
                sh[i] = 8'h00;
        end else begin
            cyc++;
            x = er();
            chk("gpio", route[39:0], x[39:0]);
            chk("lcd", route[120:72], x[120:72]);
            chk("misc", route[71:40], x[71:40]);
            if (pready === 1'b1) begin
                chk("pready owner", q.size() > 0, 1'b1);
                n = q.pop_front();
                chk("pslverr", pslverr, n.err);
                chk("prdata", prdata, (n.we || n.err) ? 32'h0 : {24'h0, sh[n.idx]});
                if (n.upd)
                    sh[n.idx] = n.d;
            end
            if (cyc == 6000) begin
                fails++;
                results();
            end
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
        void'($urandom(11740));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_all();
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 11; i++)
                xfer(1'b1, 12'(4 * i), 8'(r * 8'h55), 4'hF);
            rd_all();
        end
        repeat (80)
            xfer(1'($urandom), 12'(4 * $urandom_range(10)), 8'($urandom), 4'($urandom));
        // refused addresses and a write with the low lane strobe off
        xfer(1'b1, 12'h02C, 8'hFF, 4'hF);
        xfer(1'b0, 12'h02C, 8'h00, 4'hF);
        xfer(1'b1, 12'h001, 8'hFF, 4'hF);
        xfer(1'b0, 12'hFFE, 8'h00, 4'hF);
        xfer(1'b1, 12'h000, 8'hFF, 4'hE);
        rd_all();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_all();
        chk("notes left", q.size(), 0);
        results();
    end
endmodule
